// File: logic/ims_master.sv
// i2c master receive, acknowledge, stop and arbitration sequencer
// Summary of operation
// - receive byte, then set irq and full
// - byte done clears receive_enable_flag, holds clock low
// - reading data buffer clears full flag
// - ack pulls clock low, drives ack bit
// - clock high plus baud, clock low, idle
// - ack bit done sets irq flag
// - data write during ack sets collision
// - stop pulls data low, then counts baud
// - timeout releases clock, data one later
// - stop seen sets flag, later irq
// - data write during stop sets collision
// - reset disables port, aborts transfer
// - reset or disable clears start/stop seen
// - sleeping receive completion wakes processor if irq enabled
// - irq enabled raises irq on stop seen while idle
// - expected high sampled low is collision
// - arbitration covers address, data, conditions
// - transmit collision clears full, releases lines
// - condition collision clears its enable bit
// - after collision, stop sets irq flag
// - next write restarts byte from bit one
// - baud counter reloads each timing period
//
// Added by the designer: the address map and register access over APB.
module ims_master (
    input wire logic CLK, // system clock
    input wire logic SRST, // sync reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [7:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped
    output logic [31:0] PRDATA, // apb read data
    input wire logic SCL_I, // clock line level
    output logic SCL_O, // clock line drive value
    output logic SCL_OEN, // clock pull, low drives
    input wire logic SDA_I, // data line level
    output logic SDA_O, // data line drive value
    output logic SDA_OEN, // data pull, low drives
    input wire logic SLEEP, // processor asleep
    output logic WAKE // wake request pulse
);
    ims_pkg::ims_q_t q; // registered state
    ims_pkg::ims_q_t d; // next state
    logic scl_s; // synchronised clock line
    logic sda_s; // synchronised data line
    logic tick; // baud period over
    logic acc; // apb access edge
    logic st_ev; // start seen on bus
    logic sp_ev; // stop seen on bus

    // address match used by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // baud counter step: reload at zero, else count down
    function automatic logic [7:0] bstep(input logic [7:0] c, input logic [7:0] r);
        bstep = (c == 8'h00) ? r : c - 8'h01;
    endfunction

    assign scl_s = q.scl_m[1];
    assign sda_s = q.sda_m[1];
    assign tick = (q.cnt == 8'h00);
    assign acc = PSEL && PENABLE && q.pready;
    assign st_ev = scl_s && q.sda_p && !sda_s;
    assign sp_ev = scl_s && !q.sda_p && sda_s;

    // next-state logic for the whole block
    always_comb
    begin
        d = q;
        d.scl_m = {q.scl_m[0], SCL_I};
        d.sda_m = {q.sda_m[0], SDA_I};
        d.sda_p = sda_s;
        d.wake = 1'b0;
        // registered answer: data latched in setup, ready in access
        d.pready = PSEL && !PENABLE;
        d.pslverr = 1'b0;
        d.prdata = 32'h0000_0000;
        if (PSEL && !PENABLE)
        begin
            if (hit(PADDR, ims_pkg::OFF_CTRL))
            begin
                d.prdata[7:0] = {1'b0, q.irqen, q.ack_data_bit, q.ack_sequence_enable, q.receive_enable_flag, q.stop_cond_enable, q.start_cond_enable, q.en};
            end
            else if (hit(PADDR, ims_pkg::OFF_STAT))
            begin
                d.prdata[7:0] = {q.st != ims_pkg::ST_IDLE, q.ackst, q.pdet, q.sdet,
                                 q.bcl, q.write_collision_flag, q.irqf, q.bf};
            end
            else if (hit(PADDR, ims_pkg::OFF_DATA))
            begin
                d.prdata[7:0] = q.dbuf;
            end
            else if (hit(PADDR, ims_pkg::OFF_BAUD))
            begin
                d.prdata[7:0] = q.baud;
            end
            else
            begin
                d.pslverr = 1'b1; // unmapped address
            end
        end
        // software side effects at the access edge
        if (acc && !PWRITE && hit(PADDR, ims_pkg::OFF_DATA))
        begin
            d.bf = 1'b0;
        end
        if (acc && PWRITE)
        begin
            if (hit(PADDR, ims_pkg::OFF_CTRL))
            begin
                d.en = PWDATA[ims_pkg::C_EN];
                d.ack_data_bit = PWDATA[ims_pkg::C_ACK_DATA_BIT];
                d.irqen = PWDATA[ims_pkg::C_IRQEN];
                // commands only start from idle, one at a time
                if (q.en && q.st == ims_pkg::ST_IDLE)
                begin
                    if (PWDATA[ims_pkg::C_SEN])
                    begin
                        d.start_cond_enable = 1'b1;
                    end
                    else if (PWDATA[ims_pkg::C_PEN])
                    begin
                        d.stop_cond_enable = 1'b1;
                    end
                    else if (PWDATA[ims_pkg::C_RECEIVE_ENABLE_FLAG])
                    begin
                        d.receive_enable_flag = 1'b1;
                    end
                    else if (PWDATA[ims_pkg::C_ACK_SEQUENCE_ENABLE])
                    begin
                        d.ack_sequence_enable = 1'b1;
                    end
                end
            end
            else if (hit(PADDR, ims_pkg::OFF_STAT))
            begin
                // write one to clear; hardware sets below win
                if (PWDATA[ims_pkg::S_IRQ]) d.irqf = 1'b0;
                if (PWDATA[ims_pkg::S_WRITE_COLLISION_FLAG]) d.write_collision_flag = 1'b0;
                if (PWDATA[ims_pkg::S_BCL]) d.bcl = 1'b0;
            end
            else if (hit(PADDR, ims_pkg::OFF_DATA))
            begin
                if (q.st != ims_pkg::ST_IDLE || q.ack_sequence_enable || q.stop_cond_enable || q.start_cond_enable)
                begin
                    d.write_collision_flag = 1'b1;
                end
                else if (q.en)
                begin
                    // fresh byte always starts at its first bit
                    d.dbuf = PWDATA[7:0];
                    d.sh = PWDATA[7:0];
                    d.bitn = 4'h0;
                    d.bf = 1'b1;
                    d.ph = 1'b0;
                    d.cnt = q.baud;
                    d.sda_oen = PWDATA[7];
                    d.st = ims_pkg::ST_TX;
                end
            end
            else if (hit(PADDR, ims_pkg::OFF_BAUD))
            begin
                d.baud = PWDATA[7:0];
            end
        end
        // bus condition monitor, runs in every state
        if (st_ev)
        begin
            d.sdet = 1'b1;
            d.pdet = 1'b0;
        end
        if (sp_ev)
        begin
            d.pdet = 1'b1;
            d.sdet = 1'b0;
            if (q.irqen && q.st == ims_pkg::ST_IDLE)
            begin
                d.irqf = 1'b1;
            end
        end
        // counter runs in the active states, reloaded while stretched; ST_STOP1 and ST_STOP4 before the stop hold it at baud
        if (q.st != ims_pkg::ST_IDLE)
        begin
            if (q.ph && !scl_s)
            begin
                d.cnt = q.baud;
            end
            else
            begin
                d.cnt = bstep(q.cnt, q.baud);
            end
        end
        case (q.st)
            ims_pkg::ST_IDLE:
            begin
                d.ph = 1'b0;
                d.cnt = q.baud;
                if (q.start_cond_enable)
                begin
                    if (!scl_s || !sda_s)
                    begin
                        d.bcl = 1'b1;
                        d.start_cond_enable = 1'b0;
                    end
                    else
                    begin
                        d.sda_oen = 1'b0;
                        d.st = ims_pkg::ST_START;
                    end
                end
                else if (q.receive_enable_flag)
                begin
                    d.sda_oen = 1'b1;
                    d.bitn = 4'h0;
                    d.st = ims_pkg::ST_RX;
                end
                else if (q.ack_sequence_enable)
                begin
                    d.scl_oen = 1'b0;
                    d.sda_oen = q.ack_data_bit;
                    d.st = ims_pkg::ST_ACK;
                end
                else if (q.stop_cond_enable)
                begin
                    d.scl_oen = 1'b0;
                    d.sda_oen = 1'b0;
                    d.st = ims_pkg::ST_STOP1;
                end
            end
            ims_pkg::ST_START:
            begin
                if (tick)
                begin
                    d.scl_oen = 1'b0;
                    d.start_cond_enable = 1'b0;
                    d.irqf = 1'b1;
                    d.st = ims_pkg::ST_IDLE;
                end
            end
            ims_pkg::ST_TX, ims_pkg::ST_RX, ims_pkg::ST_ACK:
            begin
                if (!q.ph)
                begin
                    if (tick)
                    begin
                        d.scl_oen = 1'b1;
                        d.ph = 1'b1;
                    end
                end
                else if (scl_s && tick)
                begin
                    d.scl_oen = 1'b0;
                    d.ph = 1'b0;
                    d.bitn = q.bitn + 4'h1;
                    if (q.st == ims_pkg::ST_ACK)
                    begin
                        d.ack_sequence_enable = 1'b0;
                        d.irqf = 1'b1;
                        d.st = ims_pkg::ST_IDLE;
                    end
                    else if (q.st == ims_pkg::ST_RX)
                    begin
                        d.sh = {q.sh[6:0], sda_s};
                        if (q.bitn == ims_pkg::BITS_BYTE - 4'h1)
                        begin
                            d.dbuf = {q.sh[6:0], sda_s};
                            d.bf = 1'b1;
                            d.irqf = 1'b1;
                            d.receive_enable_flag = 1'b0;
                            d.wake = SLEEP && q.irqen;
                            d.st = ims_pkg::ST_IDLE;
                        end
                    end
                    else if (q.bitn == ims_pkg::BITS_BYTE)
                    begin
                        d.ackst = sda_s;
                        d.irqf = 1'b1;
                        d.st = ims_pkg::ST_IDLE;
                    end
                    else
                    begin
                        d.sh = {q.sh[6:0], 1'b0};
                        d.sda_oen = (q.bitn == ims_pkg::BITS_BYTE - 4'h1) ? 1'b1 : q.sh[6];
                        if (q.bitn == ims_pkg::BITS_BYTE - 4'h1)
                        begin
                            d.bf = 1'b0;
                        end
                    end
                end
                // released data line read low while clock high
                if (q.ph && scl_s && q.sda_oen && !sda_s && q.st != ims_pkg::ST_RX
                    && !(q.st == ims_pkg::ST_TX && q.bitn == ims_pkg::BITS_BYTE))
                begin
                    d.bcl = 1'b1;
                    d.st = ims_pkg::ST_IDLE;
                    d.scl_oen = 1'b1;
                    d.sda_oen = 1'b1;
                    d.ack_sequence_enable = 1'b0;
                    d.ph = 1'b0;
                    if (q.st == ims_pkg::ST_TX)
                    begin
                        d.bf = 1'b0;
                    end
                end
            end
            ims_pkg::ST_STOP1:
            begin
                // wait for the data line to read low
                d.cnt = q.baud;
                if (!sda_s)
                begin
                    d.st = ims_pkg::ST_STOP2;
                end
            end
            ims_pkg::ST_STOP2:
            begin
                if (tick)
                begin
                    d.scl_oen = 1'b1;
                    d.st = ims_pkg::ST_STOP3;
                end
            end
            ims_pkg::ST_STOP3:
            begin
                if (tick)
                begin
                    d.sda_oen = 1'b1;
                    d.st = ims_pkg::ST_STOP4;
                end
            end
            ims_pkg::ST_STOP4:
            begin
                // hold the counter until the stop is seen
                if (!q.pdet)
                begin
                    d.cnt = q.baud;
                end
                if (!scl_s)
                begin
                    d.bcl = 1'b1;
                    d.stop_cond_enable = 1'b0;
                    d.scl_oen = 1'b1;
                    d.st = ims_pkg::ST_IDLE;
                end
                else if (q.pdet && tick)
                begin
                    d.stop_cond_enable = 1'b0;
                    d.irqf = 1'b1;
                    d.st = ims_pkg::ST_IDLE;
                end
            end
            default:
            begin
                d.st = ims_pkg::ST_IDLE;
            end
        endcase
        // a disabled port aborts and forgets bus conditions
        if (!q.en)
        begin
            d.st = ims_pkg::ST_IDLE;
            d.scl_oen = 1'b1;
            d.sda_oen = 1'b1;
            d.start_cond_enable = 1'b0;
            d.stop_cond_enable = 1'b0;
            d.receive_enable_flag = 1'b0;
            d.ack_sequence_enable = 1'b0;
            d.sdet = 1'b0;
            d.pdet = 1'b0;
        end
    end

    // state register; lines start released, port disabled
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            q <= '0;
            q.baud <= ims_pkg::BAUD_RST;
            q.scl_oen <= 1'b1;
            q.sda_oen <= 1'b1;
            q.scl_m <= 2'b11;
            q.sda_m <= 2'b11;
            q.sda_p <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign PRDATA = q.prdata;
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OEN = q.scl_oen;
    assign SDA_OEN = q.sda_oen;
    assign WAKE = q.wake;

    property p_rx_done;
        @(posedge CLK) disable iff (SRST)
        $fell(q.receive_enable_flag) && q.en |-> q.bf && q.irqf && !q.scl_oen;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("rx end flags wrong");

    property p_rd_clr;
        @(posedge CLK) disable iff (SRST)
        acc && !PWRITE && PADDR == ims_pkg::OFF_DATA && q.st == ims_pkg::ST_IDLE |=> !q.bf;
    endproperty
    a_rd_clr: assert property (p_rd_clr) else $error("read kept full flag");

    property p_ack_go;
        @(posedge CLK) disable iff (SRST)
        $rose(q.ack_sequence_enable) && q.st == ims_pkg::ST_IDLE |=> !q.scl_oen && q.sda_oen == q.ack_data_bit;
    endproperty
    a_ack_go: assert property (p_ack_go) else $error("ack not driven");

    property p_ack_end;
        @(posedge CLK) disable iff (SRST)
        $fell(q.ack_sequence_enable) && !$rose(q.bcl) && q.en |-> q.irqf && !q.scl_oen;
    endproperty
    a_ack_end: assert property (p_ack_end) else $error("ack end wrong");

    property p_write_collision_flag;
        @(posedge CLK) disable iff (SRST)
        acc && PWRITE && PADDR == ims_pkg::OFF_DATA && q.st == ims_pkg::ST_ACK
        |=> q.write_collision_flag && q.dbuf == $past(q.dbuf);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("write collision missed");

    property p_stop_scl;
        @(posedge CLK) disable iff (SRST)
        q.st == ims_pkg::ST_STOP2 && tick && q.en |=> q.scl_oen && !q.sda_oen;
    endproperty
    a_stop_scl: assert property (p_stop_scl) else $error("stop clock release");

    property p_rst;
        @(posedge CLK)
        SRST |=> !q.en && !q.sdet && !q.pdet && q.scl_oen && q.sda_oen;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");

    property p_bcl;
        @(posedge CLK) disable iff (SRST)
        $rose(q.bcl) |-> q.st == ims_pkg::ST_IDLE && q.scl_oen;
    endproperty
    a_bcl: assert property (p_bcl) else $error("collision not idle");
endmodule

// File: logic/ims_pkg.sv
// shared constants and types for the i2c master sequencer
package ims_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0C;
    // master_control_reg bit positions
    localparam int C_EN = 0;
    localparam int C_SEN = 1;
    localparam int C_PEN = 2;
    localparam int C_RECEIVE_ENABLE_FLAG = 3;
    localparam int C_ACK_SEQUENCE_ENABLE = 4;
    localparam int C_ACK_DATA_BIT = 5;
    localparam int C_IRQEN = 6;
    // port_status_reg bit positions
    localparam int S_BF = 0;
    localparam int S_IRQ = 1;
    localparam int S_WRITE_COLLISION_FLAG = 2;
    localparam int S_BCL = 3;
    localparam int S_SDET = 4;
    localparam int S_PDET = 5;
    localparam int S_ACKST = 6;
    localparam int S_BUSY = 7;
    // baud reset value and bits per byte
    localparam logic [7:0] BAUD_RST = 8'h09;
    localparam logic [3:0] BITS_BYTE = 4'h8;
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_START = 4'b0001,
        ST_TX = 4'b0010,
        ST_RX = 4'b0011,
        ST_ACK = 4'b0100,
        ST_STOP1 = 4'b0101,
        ST_STOP2 = 4'b0110,
        ST_STOP3 = 4'b0111,
        ST_STOP4 = 4'b1000
    } ims_state_t;
    // whole block state
    typedef struct packed {
        ims_state_t st;
        logic ph;
        logic [7:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] dbuf;
        logic [7:0] baud;
        logic scl_oen;
        logic sda_oen;
        logic en, start_cond_enable, stop_cond_enable, receive_enable_flag, ack_sequence_enable, ack_data_bit, irqen;
        logic bf, irqf, write_collision_flag, bcl, sdet, pdet, ackst;
        logic [1:0] scl_m;
        logic [1:0] sda_m;
        logic sda_p;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wake;
    } ims_q_t;
endpackage

// File: test/ims_slave.sv
// far-side model: slave that sends bytes, samples bits, stretches and collides
module ims_slave (
    input wire logic clk, // system clock, used to find line edges
    input wire logic scl, // resolved clock line level
    input wire logic sda, // resolved data line level
    input wire logic load, // pulse: arm a byte for the master to read
    input wire logic [7:0] byte_in, // byte handed to the master, msb first
    input wire logic collide, // pull data low from the next clock fall
    input wire logic stretch, // hold the clock low after each fall
    output logic scl_rel, // low pulls the clock line
    output logic sda_rel, // low pulls the data line
    output logic [8:0] seen // data levels taken at the last nine clock rises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q = 1'b1; // last clock level, for edge finding
    logic [7:0] sh = 8'hFF; // bits still to send
    logic [3:0] left = 4'h0; // count of bits still to send
    logic [5:0] hold = 6'h00; // stretch cycles left
    logic grab = 1'b0; // data line held low for a collision
    initial seen = 9'h000;
    // bits change only while the clock is low, so no false start or stop
    always @(posedge clk)
    begin
        scl_q <= scl;
        if (load)
        begin
            sh <= byte_in;
            left <= 4'h8;
        end
        else if (scl_q && !scl && left != 4'h0)
        begin
            sh <= {sh[6:0], 1'b1};
            left <= left - 4'h1;
        end
        if (!scl_q && scl)
            seen <= {seen[7:0], sda};
        if (collide && scl_q && !scl)
            grab <= 1'b1;
        else if (!collide)
            grab <= 1'b0;
        hold <= (scl_q && !scl && stretch) ? 6'h28 : (hold != 6'h00 ? hold - 6'h01 : 6'h00);
    end
    // released lines float to the pull-up level
    assign sda_rel = !grab && (left == 4'h0 || sh[7]);
    assign scl_rel = (hold == 6'h00);
endmodule

// File: test/ims_master_tb_top.sv
// self-checking bench for the i2c master sequencer
module ims_master_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] K_EN = 32'h1 << ims_pkg::C_EN; // port enable
    localparam logic [31:0] K_IE = 32'h1 << ims_pkg::C_IRQEN; // irq enable
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic PREADY, PSLVERR, SCL_O, SCL_OEN, SDA_O, SDA_OEN, WAKE;
    logic [31:0] PRDATA;
    logic SLEEP = 1'b0;
    logic s_load = 1'b0;
    logic [7:0] s_byte = 8'h00;
    logic s_coll = 1'b0;
    logic s_str = 1'b0;
    logic s_scl_rel, s_sda_rel, scl_line, sda_line;
    logic [8:0] s_seen;
    logic wake_seen = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    // open-drain lines: any party pulling low wins, else the pull-up
    assign scl_line = (SCL_OEN ? 1'b1 : SCL_O) & s_scl_rel;
    assign sda_line = (SDA_OEN ? 1'b1 : SDA_O) & s_sda_rel;
    ims_master uut (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
        .SCL_I(scl_line), .SCL_O(SCL_O), .SCL_OEN(SCL_OEN), .SDA_I(sda_line), .SDA_O(SDA_O),
        .SDA_OEN(SDA_OEN), .SLEEP(SLEEP), .WAKE(WAKE));
    ims_slave slv (.clk(CLK), .scl(scl_line), .sda(sda_line), .load(s_load), .byte_in(s_byte),
        .collide(s_coll), .stretch(s_str), .scl_rel(s_scl_rel), .sda_rel(s_sda_rel),
        .seen(s_seen));
    // 100 MHz clock
    initial
    begin
        forever #5 CLK = ~CLK;
    end
    // the wake pulse lasts one cycle, so latch it
    always @(posedge CLK)
    begin
        if (WAKE === 1'b1)
            wake_seen <= 1'b1;
    end
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one comparison
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the request holds until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (n >= 50)
        begin
            miscompares++;
            summarize();
        end
        @(posedge CLK);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask
    // polls a register bit until it reads the wanted level, bounded
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        logic [31:0] d;
        int n;
        n = 0;
        rd(a, d);
        while (d[b] !== v && n < 400)
        begin
            rd(a, d);
            n++;
        end
        if (n >= 400)
        begin
            miscompares++;
            summarize();
        end
    endtask
    // reset values, unmapped access, released lines
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        rd(ims_pkg::OFF_CTRL, d);
        chk(d, 32'h0);
        rd(ims_pkg::OFF_STAT, d);
        chk(d, 32'h0);
        rd(ims_pkg::OFF_BAUD, d);
        chk(d, {24'h0, ims_pkg::BAUD_RST});
        apb(1'b0, 8'h10, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        chk({30'h0, SCL_OEN, SDA_OEN}, 32'h3);
        $display("test reset done");
    endtask
    // master receive from a slow slave while the processor sleeps
    task automatic t_rx();
        logic [31:0] d;
        wr(ims_pkg::OFF_BAUD, 32'h0000000C);
        wr(ims_pkg::OFF_CTRL, K_EN | K_IE);
        SLEEP <= 1'b1;
        s_str <= 1'b1;
        s_byte <= 8'hA5;
        s_load <= 1'b1;
        @(posedge CLK);
        s_load <= 1'b0;
        wr(ims_pkg::OFF_CTRL, K_EN | K_IE | (32'h1 << ims_pkg::C_RECEIVE_ENABLE_FLAG));
        wait_bit(ims_pkg::OFF_STAT, ims_pkg::S_BF, 1'b1);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_IRQ]}, 32'h1);
        rd(ims_pkg::OFF_CTRL, d);
        chk({31'h0, d[ims_pkg::C_RECEIVE_ENABLE_FLAG]}, 32'h0);
        chk({31'h0, scl_line}, 32'h0);
        chk({31'h0, wake_seen}, 32'h1);
        rd(ims_pkg::OFF_DATA, d);
        chk(d, 32'h000000A5);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_BF]}, 32'h0);
        SLEEP <= 1'b0;
        s_str <= 1'b0;
        $display("test receive done");
    endtask
    // acknowledge sequence with a data write colliding inside it
    task automatic t_ack(input logic ack_data_bit);
        logic [31:0] d;
        wr(ims_pkg::OFF_STAT, 32'h6);
        wr(ims_pkg::OFF_CTRL, K_EN | K_IE | (32'h1 << ims_pkg::C_ACK_SEQUENCE_ENABLE)
            | ({31'h0, ack_data_bit} << ims_pkg::C_ACK_DATA_BIT));
        wr(ims_pkg::OFF_DATA, 32'h0000005A);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_WRITE_COLLISION_FLAG]}, 32'h1);
        wait_bit(ims_pkg::OFF_CTRL, ims_pkg::C_ACK_SEQUENCE_ENABLE, 1'b0);
        chk({31'h0, s_seen[0]}, {31'h0, ack_data_bit});
        chk({31'h0, scl_line}, 32'h0);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_IRQ]}, 32'h1);
        rd(ims_pkg::OFF_DATA, d);
        chk(d, 32'h000000A5);
        $display("test ack %0d done", ack_data_bit);
    endtask
    // stop condition with a data write colliding inside it
    task automatic t_stop();
        logic [31:0] d;
        wr(ims_pkg::OFF_STAT, 32'h6);
        wr(ims_pkg::OFF_CTRL, K_EN | K_IE | (32'h1 << ims_pkg::C_PEN));
        wr(ims_pkg::OFF_DATA, 32'h00000011);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_WRITE_COLLISION_FLAG]}, 32'h1);
        wait_bit(ims_pkg::OFF_CTRL, ims_pkg::C_PEN, 1'b0);
        chk({30'h0, scl_line, sda_line}, 32'h3);
        rd(ims_pkg::OFF_STAT, d);
        chk({30'h0, d[ims_pkg::S_PDET], d[ims_pkg::S_IRQ]}, 32'h3);
        rd(ims_pkg::OFF_DATA, d);
        chk(d, 32'h000000A5);
        $display("test stop done");
    endtask
    // lost arbitration, stop seen afterwards, then a clean resend
    task automatic t_coll();
        logic [31:0] d;
        wr(ims_pkg::OFF_STAT, 32'hE);
        s_coll <= 1'b1;
        wr(ims_pkg::OFF_DATA, 32'h000000FF);
        wait_bit(ims_pkg::OFF_STAT, ims_pkg::S_BCL, 1'b1);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_BF]}, 32'h0);
        chk({30'h0, SCL_OEN, SDA_OEN}, 32'h3);
        wr(ims_pkg::OFF_STAT, 32'h2);
        s_coll <= 1'b0;
        wait_bit(ims_pkg::OFF_STAT, ims_pkg::S_IRQ, 1'b1);
        rd(ims_pkg::OFF_STAT, d);
        chk({31'h0, d[ims_pkg::S_PDET]}, 32'h1);
        // bus is free again: claim it with a start so the first bit gets a clock rise
        wr(ims_pkg::OFF_CTRL, K_EN | K_IE | (32'h1 << ims_pkg::C_SEN));
        wait_bit(ims_pkg::OFF_CTRL, ims_pkg::C_SEN, 1'b0);
        rd(ims_pkg::OFF_STAT, d);
        chk({30'h0, d[ims_pkg::S_SDET], d[ims_pkg::S_PDET]}, 32'h2);
        wr(ims_pkg::OFF_STAT, 32'hE);
        wr(ims_pkg::OFF_DATA, 32'h000000C3);
        wait_bit(ims_pkg::OFF_STAT, ims_pkg::S_IRQ, 1'b1);
        chk({24'h0, s_seen[8:1]}, 32'h000000C3);
        // disabling the port forgets bus conditions and lets go of the lines
        wr(ims_pkg::OFF_CTRL, 32'h0);
        rd(ims_pkg::OFF_STAT, d);
        chk({30'h0, d[ims_pkg::S_SDET], d[ims_pkg::S_PDET]}, 32'h0);
        chk({30'h0, SCL_OEN, SDA_OEN}, 32'h3);
        $display("test collision done");
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        t_reset();
        t_rx();
        t_ack(1'b0);
        t_ack(1'b1);
        t_stop();
        t_coll();
        summarize();
    end
endmodule
